//--- core/ee_seq_map.svh
// Register offsets, field positions, reset values, keys and timing counts
// Assumes inclusion by bare name from the sequencer, its page buffer and its array
`ifndef EE_SEQ_MAP_SVH
`define EE_SEQ_MAP_SVH

// Register byte offsets on the APB side
`define OFS_COMMAND      12'h000
`define OFS_CONTROL_A    12'h004
`define OFS_STATUS       12'h008
`define OFS_ADDRESS      12'h00c
`define OFS_DATA_LOW     12'h010

// Field positions
`define EXEC_BIT         0
`define NONVOLATILE_ACCESS_ENABLED_BIT        1
`define BUSY_BIT         7

// Reset values and fixed data
`define COMMAND_RST      7'h00
`define ADDRESS_RST      16'h0000
`define DATA_RST         8'h00
`define ERASED_BYTE      8'hff
`define DBG_RESET_KEY    8'h59

// Debug link linear space
`define FLASH_BASE       25'h0800000
`define EEPROM_BASE      25'h08c0000
`define PROD_SIG_BASE    25'h08e0200
`define USER_SIG_BASE    25'h08e0400
`define SIG_SIZE         25'h0000200
`define FUSE_BASE        25'h08f0020
`define FUSE_SIZE        25'h0000010
`define DATAMEM_BASE     25'h1000000

// Timing
`define CCP_WINDOW_CYC   3'h4
`define CLK_PERIOD_NS    100
`define EE_OP_TIME_NS    2000
`define EE_OP_CYC        ((`EE_OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- core/ee_seq_pkg.sv
// Types shared by the EEPROM command sequencer
// Assumes nothing beyond a SystemVerilog compiler
package ee_seq_pkg;
    // Command select codes
    typedef enum logic [6:0] {
        CMD_NOP = 7'h00, CMD_READ_EE = 7'h06, CMD_ERASE_EE = 7'h30, CMD_ERASE_PAGE = 7'h32,
        CMD_LOAD_BUF = 7'h33, CMD_WRITE_PAGE = 7'h34, CMD_ERASE_WRITE = 7'h35, CMD_ERASE_BUF = 7'h36
    } command_type;
    // Debug link address regions
    typedef enum logic [2:0] {
        RG_NONE = 3'h0, RG_FLASH = 3'h1, RG_EEPROM = 3'h2, RG_FUSE = 3'h3,
        RG_PROD_SIG = 3'h4, RG_USER_SIG = 3'h5, RG_DATAMEM = 3'h6
    } region_type;
    // Sequencer states
    typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_WALK = 3'b010, ST_WAIT = 3'b100} state_type;
endpackage

//--- core/ee_store_if.sv
// Links the sequencer to its page buffer and EEPROM array
// Assumes all three ends run on one clock
`timescale 1ns/10ps
interface ee_store_if #(parameter int BYTE_BITS = 5, parameter int PAGE_BITS = 3);
    logic                           buf_clear;
    logic                           buf_load;
    logic [BYTE_BITS-1:0]           buf_idx;
    logic [7:0]                     buf_wdata;
    logic [BYTE_BITS-1:0]           buf_rd_idx;
    logic [7:0]                     buf_rdata;
    logic                           buf_rtag;
    logic                           arr_we;
    logic [PAGE_BITS+BYTE_BITS-1:0] arr_waddr;
    logic [7:0]                     arr_wdata;
    logic [PAGE_BITS+BYTE_BITS-1:0] arr_raddr;
    logic [7:0]                     arr_rdata;
    modport seq  (output buf_clear, buf_load, buf_idx, buf_wdata, buf_rd_idx, arr_we, arr_waddr,
                  arr_wdata, arr_raddr, input buf_rdata, buf_rtag, arr_rdata);
    modport pbuf (input buf_clear, buf_load, buf_idx, buf_wdata, buf_rd_idx, output buf_rdata, buf_rtag);
    modport arr  (input arr_we, arr_waddr, arr_wdata, arr_raddr, output arr_rdata);
endinterface

//--- core/ee_page_buffer.sv
// Tagged EEPROM page buffer, one byte and one tag per entry
// Assumes the sequencer never loads and clears in one cycle
`timescale 1ns/10ps
`include "ee_seq_map.svh"
module ee_page_buffer #(parameter int BYTE_BITS = 5) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    ee_store_if.pbuf  bus
);
    logic [7:0] data_reg [2**BYTE_BITS];
    logic       tag_reg  [2**BYTE_BITS];

    // One entry per generate pass
    for (genvar e = 0; e < 2**BYTE_BITS; e++) begin : g_entry
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                data_reg[e] <= `DATA_RST;
                tag_reg[e]  <= 1'b0;
            end else if (bus.buf_clear) begin
                data_reg[e] <= `DATA_RST;
                tag_reg[e]  <= 1'b0;
            end else if (bus.buf_load && bus.buf_idx == BYTE_BITS'(e)) begin
                data_reg[e] <= bus.buf_wdata;
                tag_reg[e]  <= 1'b1;
            end
        end
    end

    // Read port for the page walk
    assign bus.buf_rdata = data_reg[bus.buf_rd_idx];
    assign bus.buf_rtag  = tag_reg[bus.buf_rd_idx];
endmodule

//--- core/ee_array.sv
// EEPROM array held in flip-flops, one write and one read port
// Assumes erase writes the erased byte value through the write port
`timescale 1ns/10ps
`include "ee_seq_map.svh"
module ee_array #(parameter int AW = 8) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    ee_store_if.arr   bus
);
    logic [7:0] mem_reg [2**AW];

    // Per-byte storage
    for (genvar a = 0; a < 2**AW; a++) begin : g_byte
        always_ff @(posedge i_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                mem_reg[a] <= `ERASED_BYTE;
            end else if (bus.arr_we && bus.arr_waddr == AW'(a)) begin
                mem_reg[a] <= bus.arr_wdata;
            end
        end
    end

    assign bus.arr_rdata = mem_reg[bus.arr_raddr];
endmodule

//--- core/ee_seq_top.sv
// EEPROM command sequencer: APB registers, debug link memory port, page ops
// Assumes one 10 MHz clock and APB and debug requests synchronous to it
//
// What this block does
// - Buffer-load command: data write loads tagged byte
// - Repeated address/data loads need no reissue
// - Buffer erase clears bytes and tags
// - Self-programmed strobe needs unlock window
// - Busy holds from non-read strobe until completion
// - Page erase touches tagged bytes only
// - Page write programs tagged bytes only
// - Erase-write: erase then program, uninterruptible
// - Full erase: tagged bytes of every page
// - Read command fetches byte into data register
// - Debug access only once access enabled
// - Decode flash, EEPROM, data memory bases
// - Decode fuse and signature row bases
// - Debug accesses address memory directly
// - Debug addresses are byte addresses
// - Buffer location from low address bits
// - Reads blocked while memory busy
// - Decode buffer load and buffer erase codes
// - Decode page erase, write, erase-write codes
// - Decode full erase, read, no-operation
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "ee_seq_map.svh"
module ee_seq_top #(
    parameter int BYTE_BITS = 5,
    parameter int PAGE_BITS = 3,
    parameter int OP_CYCLES = `EE_OP_CYC
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [11:0]             i_paddr,
    input  wire logic [31:0]             i_pwdata,
    output logic      [31:0]             o_prdata,
    output logic                         o_pready,
    output logic                         o_pslverr,
    input  wire logic                    i_ccp_unlock,
    input  wire logic                    i_dbg_reset_write,
    input  wire logic [7:0]              i_dbg_reset_data,
    input  wire logic                    i_dbg_nvm_key,
    input  wire logic                    i_dbg_req,
    input  wire logic                    i_dbg_write,
    input  wire logic [24:0]             i_dbg_addr,
    input  wire logic [7:0]              i_dbg_wdata,
    output logic                         o_dbg_ack,
    output logic      [7:0]              o_dbg_rdata,
    output ee_seq_pkg::region_type       o_dbg_region,
    output logic                         o_busy,
    output logic                         o_nonvolatile_access_enabled
);
    import ee_seq_pkg::*;

    localparam int          AW      = PAGE_BITS + BYTE_BITS;
    localparam logic [24:0] EE_SPAN = 25'(2**AW);

    ee_store_if #(.BYTE_BITS(BYTE_BITS), .PAGE_BITS(PAGE_BITS)) st ();

    ee_page_buffer #(.BYTE_BITS(BYTE_BITS)) u_buf (.i_clk(i_clk), .i_resetn(i_resetn), .bus(st.pbuf));
    ee_array #(.AW(AW)) u_arr (.i_clk(i_clk), .i_resetn(i_resetn), .bus(st.arr));

    logic [6:0]           command_reg;
    logic                 exec_reg;
    logic [15:0]          address_reg;
    logic [7:0]           data_low_reg;
    state_type            state_reg;
    command_type          op_reg;
    logic [AW-1:0]        walk_reg;
    logic [PAGE_BITS-1:0] page_reg;
    logic                 erase_phase_reg;
    logic [15:0]          wait_reg;
    logic [2:0]           ccp_cnt_reg;
    logic                 key_seen_reg;
    logic                 nonvolatile_access_enabled_pend_reg;
    logic                 nonvolatile_access_enabled_reg;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    logic apb_acc, mapped, wr_cmd, wr_ctrl, wr_addr, wr_data;
    assign apb_acc = i_psel & i_penable;
    assign wr_cmd  = apb_acc & i_pwrite & (i_paddr == `OFS_COMMAND);
    assign wr_ctrl = apb_acc & i_pwrite & (i_paddr == `OFS_CONTROL_A);
    assign wr_addr = apb_acc & i_pwrite & (i_paddr == `OFS_ADDRESS);
    assign wr_data = apb_acc & i_pwrite & (i_paddr == `OFS_DATA_LOW);

    // Address map check
    always_comb begin
        unique case (i_paddr)
            `OFS_COMMAND, `OFS_CONTROL_A, `OFS_STATUS, `OFS_ADDRESS, `OFS_DATA_LOW: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Zero wait states, error on unmapped offsets
    assign o_pready  = 1'b1;
    assign o_pslverr = apb_acc & ~mapped;

    ////////////////////////////////////////////////////////////////////////////
    // Command classification
    logic busy, is_action, is_read, ccp_open;
    assign busy     = (state_reg != ST_IDLE);
    assign is_read  = (command_reg == CMD_READ_EE);
    assign ccp_open = (ccp_cnt_reg != 3'h0);

    // Strobe-triggered command codes
    always_comb begin
        unique case (command_reg)
            CMD_ERASE_BUF, CMD_ERASE_PAGE, CMD_WRITE_PAGE, CMD_ERASE_WRITE,
            CMD_ERASE_EE, CMD_READ_EE: is_action = 1'b1;
            default: is_action = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Debug link region decode
    region_type region_c;
    always_comb begin
        if (i_dbg_addr >= `DATAMEM_BASE) begin
            region_c = RG_DATAMEM;
        end else if (i_dbg_addr >= `FUSE_BASE && i_dbg_addr < `FUSE_BASE + `FUSE_SIZE) begin
            region_c = RG_FUSE;
        end else if (i_dbg_addr >= `USER_SIG_BASE && i_dbg_addr < `USER_SIG_BASE + `SIG_SIZE) begin
            region_c = RG_USER_SIG;
        end else if (i_dbg_addr >= `PROD_SIG_BASE && i_dbg_addr < `PROD_SIG_BASE + `SIG_SIZE) begin
            region_c = RG_PROD_SIG;
        end else if (i_dbg_addr >= `EEPROM_BASE && i_dbg_addr < `EEPROM_BASE + EE_SPAN) begin
            region_c = RG_EEPROM;
        end else if (i_dbg_addr >= `FLASH_BASE && i_dbg_addr < `EEPROM_BASE) begin
            region_c = RG_FLASH;
        end else begin
            region_c = RG_NONE;
        end
    end

    // Debug access qualification
    logic dbg_act, dbg_ee, dbg_load, dbg_trig, dbg_read;
    assign o_dbg_ack = i_dbg_req & (~nonvolatile_access_enabled_reg | (~busy & ~exec_reg));
    assign dbg_act   = o_dbg_ack & nonvolatile_access_enabled_reg;
    assign dbg_ee    = (region_c == RG_EEPROM);
    assign dbg_load  = dbg_act & i_dbg_write & dbg_ee & (command_reg == CMD_LOAD_BUF);
    assign dbg_trig  = dbg_act & i_dbg_write & dbg_ee & (command_reg == CMD_ERASE_PAGE
                       || command_reg == CMD_WRITE_PAGE || command_reg == CMD_ERASE_WRITE);
    assign dbg_read  = dbg_act & ~i_dbg_write & dbg_ee & is_read;

    ////////////////////////////////////////////////////////////////////////////
    // Strobe acceptance and operation start
    logic exec_ok, start_go, do_read, apb_load, walk_last, op_done;
    logic [PAGE_BITS-1:0] start_page;
    assign exec_ok    = wr_ctrl & i_pwdata[`EXEC_BIT] & ~busy & ~exec_reg & is_action
                        & (ccp_open | nonvolatile_access_enabled_reg);
    assign start_go   = (exec_ok & ~is_read) | dbg_trig;
    assign start_page = dbg_trig ? i_dbg_addr[AW-1:BYTE_BITS] : address_reg[AW-1:BYTE_BITS];
    assign do_read    = exec_reg & ~busy & (op_reg == CMD_READ_EE);
    assign apb_load   = wr_data & (command_reg == CMD_LOAD_BUF) & ~busy;
    assign walk_last  = (op_reg == CMD_ERASE_EE) ? (&walk_reg) : (&walk_reg[BYTE_BITS-1:0]);
    assign op_done    = (state_reg == ST_WAIT) && (wait_reg == 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // Buffer and array steering
    assign st.buf_clear  = start_go & (command_reg == CMD_ERASE_BUF);
    assign st.buf_load   = apb_load | dbg_load;
    assign st.buf_idx    = apb_load ? address_reg[BYTE_BITS-1:0] : i_dbg_addr[BYTE_BITS-1:0];
    assign st.buf_wdata  = apb_load ? i_pwdata[7:0] : i_dbg_wdata;
    assign st.buf_rd_idx = walk_reg[BYTE_BITS-1:0];
    assign st.arr_we     = (state_reg == ST_WALK) & st.buf_rtag;
    assign st.arr_waddr  = (op_reg == CMD_ERASE_EE) ? walk_reg : {page_reg, walk_reg[BYTE_BITS-1:0]};
    assign st.arr_wdata  = erase_phase_reg ? `ERASED_BYTE : st.buf_rdata;
    assign st.arr_raddr  = exec_reg ? address_reg[AW-1:0] : i_dbg_addr[AW-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state machine
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg       <= ST_IDLE;
            op_reg          <= CMD_NOP;
            walk_reg        <= '0;
            page_reg        <= '0;
            erase_phase_reg <= 1'b0;
            wait_reg        <= 16'h0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (exec_ok) begin
                        op_reg <= command_type'(command_reg);
                    end
                    if (start_go) begin
                        op_reg          <= command_type'(command_reg);
                        page_reg        <= start_page;
                        walk_reg        <= '0;
                        erase_phase_reg <= (command_reg != CMD_WRITE_PAGE);
                        wait_reg        <= 16'(OP_CYCLES - 1);
                        state_reg       <= (command_reg == CMD_ERASE_BUF) ? ST_WAIT : ST_WALK;
                    end
                end
                ST_WALK: begin
                    walk_reg <= walk_reg + 1'b1;
                    if (walk_last) begin
                        if (op_reg == CMD_ERASE_WRITE && erase_phase_reg) begin
                            erase_phase_reg <= 1'b0;
                        end else begin
                            state_reg <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (op_done) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        wait_reg <= wait_reg - 16'h0001;
                    end
                end
            endcase
        end
    end

    // Strobe flag: set on acceptance, cleared on completion
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            exec_reg <= 1'b0;
        end else if (exec_ok) begin
            exec_reg <= 1'b1;
        end else if (op_done || do_read) begin
            exec_reg <= 1'b0;
        end
    end

    // Software registers
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            command_reg  <= `COMMAND_RST;
            address_reg  <= `ADDRESS_RST;
            data_low_reg <= `DATA_RST;
        end else begin
            if (wr_cmd) begin
                command_reg <= i_pwdata[6:0];
            end
            if (wr_addr) begin
                address_reg <= i_pwdata[15:0];
            end
            if (do_read) begin
                data_low_reg <= st.arr_rdata;
            end else if (wr_data) begin
                data_low_reg <= i_pwdata[7:0];
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            unique case (i_paddr)
                `OFS_COMMAND:   o_prdata <= {25'h0, command_reg};
                `OFS_CONTROL_A: o_prdata <= {31'h0, exec_reg};
                `OFS_STATUS:    o_prdata <= {24'h0, busy, 5'h00, nonvolatile_access_enabled_reg, 1'b0};
                `OFS_ADDRESS:   o_prdata <= {16'h0, address_reg};
                `OFS_DATA_LOW:  o_prdata <= {24'h0, data_low_reg};
                default:        o_prdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Change-protection unlock window
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ccp_cnt_reg <= 3'h0;
        end else if (i_ccp_unlock) begin
            ccp_cnt_reg <= `CCP_WINDOW_CYC;
        end else if (ccp_open) begin
            ccp_cnt_reg <= ccp_cnt_reg - 3'h1;
        end
    end

    // External programming enable: reset key, then NVM key, then active
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            key_seen_reg   <= 1'b0;
            nonvolatile_access_enabled_pend_reg <= 1'b0;
            nonvolatile_access_enabled_reg      <= 1'b0;
        end else if (i_dbg_reset_write) begin
            key_seen_reg   <= (i_dbg_reset_data == `DBG_RESET_KEY);
            nonvolatile_access_enabled_pend_reg <= 1'b0;
            nonvolatile_access_enabled_reg      <= 1'b0;
        end else begin
            if (i_dbg_nvm_key && key_seen_reg) begin
                nonvolatile_access_enabled_pend_reg <= 1'b1;
            end
            if (nonvolatile_access_enabled_pend_reg && !busy) begin
                nonvolatile_access_enabled_reg      <= 1'b1;
                nonvolatile_access_enabled_pend_reg <= 1'b0;
            end
        end
    end

    // Debug read data and region
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dbg_rdata  <= 8'h00;
            o_dbg_region <= RG_NONE;
        end else if (o_dbg_ack) begin
            o_dbg_rdata  <= dbg_read ? st.arr_rdata : 8'h00;
            o_dbg_region <= region_c;
        end
    end

    assign o_busy                       = busy;
    assign o_nonvolatile_access_enabled = nonvolatile_access_enabled_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    AST_LOAD_TAG: assert property (apb_load |-> st.buf_load && st.buf_wdata == i_pwdata[7:0])
        else $error("Buffer load not issued");
    AST_LOAD_REPEAT: assert property (wr_data && command_reg == CMD_LOAD_BUF && !busy |=> ##1 !busy)
        else $error("Buffer load made the block busy");
    AST_BUF_CLEAR: assert property (st.buf_clear |=> state_reg == ST_WAIT && exec_reg)
        else $error("Buffer erase did not start");
    AST_UNLOCK: assert property (wr_ctrl && i_pwdata[0] && !ccp_open && !nonvolatile_access_enabled_reg
        |=> !exec_reg || $past(exec_reg))
        else $error("Strobe accepted without unlock");
    AST_BUSY_HOLD: assert property (busy && !op_done |=> busy)
        else $error("Busy dropped too early");
    AST_TAGGED_ONLY: assert property (st.arr_we |-> st.buf_rtag && state_reg == ST_WALK)
        else $error("Untagged byte written");
    AST_WRITE_DATA: assert property (st.arr_we && !erase_phase_reg |-> st.arr_wdata == st.buf_rdata)
        else $error("Written byte not from buffer");
    AST_ERASE_FIRST: assert property ($fell(erase_phase_reg) && $past(state_reg) == ST_WALK
        |-> op_reg == CMD_ERASE_WRITE && state_reg == ST_WALK)
        else $error("Erase-write phase order broken");
    AST_READ_RESULT: assert property (do_read |=> data_low_reg == $past(st.arr_rdata) && !exec_reg)
        else $error("Read byte not delivered");
    AST_NO_DBG_EFFECT: assert property (!nonvolatile_access_enabled_reg |-> !dbg_load && !dbg_trig && !dbg_read)
        else $error("Debug access while disabled");
    AST_READ_BLOCK: assert property (busy && nonvolatile_access_enabled_reg |-> !o_dbg_ack)
        else $error("Debug access during busy");
    AST_STROBE_CLEAR: assert property ($fell(busy) && $past(exec_reg) |-> !exec_reg)
        else $error("Strobe outlived operation");

    COV_PAGE_WRITE: cover property (start_go && command_reg == CMD_WRITE_PAGE ##[1:100] !busy);
    COV_ERASE_WRITE: cover property ($fell(erase_phase_reg) ##[1:100] op_done);
    COV_DBG_READ: cover property (dbg_read);
    COV_APB_READ: cover property (do_read);
endmodule

//--- sim/ee_prog_model.sv
// External programmer model on the debug link of the sequencer
// Assumes the sequencer clock; link lines are scrambled between requests
`timescale 1ns/10ps
module ee_prog_model (
    input  wire logic        i_clk,
    input  wire logic        i_ack,
    input  wire logic        i_enabled,
    output logic             o_rst_wr,
    output logic      [7:0]  o_rst_data,
    output logic             o_key,
    output logic             o_req,
    output logic             o_write,
    output logic      [24:0] o_addr,
    output logic      [7:0]  o_wdata
);
    // Idle link at time zero
    initial begin
        {o_rst_wr, o_key, o_req, o_write, o_addr, o_wdata, o_rst_data} = '0;
    end
    // Reset key, memory key, then bounded poll of the enable flag
    task automatic enable_link(output logic ok);
        @(posedge i_clk) {o_rst_wr, o_rst_data} <= {1'b1, 8'h59};
        @(posedge i_clk) {o_rst_wr, o_key, o_rst_data} <= {2'b01, 8'ha6};
        @(posedge i_clk) o_key <= 1'b0;
        ok = 1'b0;
        repeat (20) if (ok !== 1'b1) @(posedge i_clk) ok = i_enabled;
    endtask
    // Byte transfer held until taken, then released with inverted lines
    task automatic xfer(input logic w, input logic [24:0] a, input logic [7:0] d);
        @(posedge i_clk) {o_req, o_write, o_addr, o_wdata} <= {1'b1, w, a, d};
        do @(posedge i_clk); while (i_ack !== 1'b1);
        {o_req, o_write, o_addr, o_wdata} <= {1'b0, ~w, ~a, ~d};
    endtask
endmodule

//--- sim/eeprom_nvm_command_sequencer_test.sv
// Self-checking bench of the EEPROM command sequencer over APB and debug link
// Assumes the core files and the programmer model are compiled first
`timescale 1ns/10ps
module eeprom_nvm_command_sequencer_test;
    import ee_seq_pkg::*;
    logic        i_clk = 1'b0, i_resetn = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic        i_ccp_unlock = 1'b0, o_pready, o_pslverr, o_dbg_ack, o_busy, o_nonvolatile_access_enabled;
    logic        i_dbg_reset_write, i_dbg_nvm_key, i_dbg_req, i_dbg_write, err, ok;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd, st;
    logic [7:0]  i_dbg_reset_data, i_dbg_wdata, o_dbg_rdata;
    logic [24:0] i_dbg_addr;
    logic [24:0] base [6] = '{25'h0800000, 25'h08c0000, 25'h08f0020, 25'h08e0200, 25'h08e0400, 25'h1000000};
    region_type  o_dbg_region;
    int          bad_count = 0, n_checks = 0;
    always #50 i_clk = ~i_clk;
    ee_seq_top #(.OP_CYCLES(2)) dut (.i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_ccp_unlock, .i_dbg_reset_write, .i_dbg_reset_data, .i_dbg_nvm_key,
        .i_dbg_req, .i_dbg_write, .i_dbg_addr, .i_dbg_wdata, .o_dbg_ack, .o_dbg_rdata, .o_dbg_region, .o_busy,
        .o_nonvolatile_access_enabled);
    ee_prog_model prog (.i_clk, .i_ack(o_dbg_ack), .i_enabled(o_nonvolatile_access_enabled),
        .o_rst_wr(i_dbg_reset_write), .o_rst_data(i_dbg_reset_data), .o_key(i_dbg_nvm_key), .o_req(i_dbg_req),
        .o_write(i_dbg_write), .o_addr(i_dbg_addr), .o_wdata(i_dbg_wdata));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk) {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_clk) i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
    endtask
    // Bounded poll until busy is low
    task automatic idle();
        rd = 32'h80;
        repeat (300) if (rd[7] !== 1'b0) apb(1'b0, 12'h008, 32'h0);
        chk("idle_busy", rd[7], 1'b0);
    endtask
    // Command, address, unlock, strobe, then wait for completion
    task automatic exec(input logic [6:0] c, input logic [15:0] a);
        apb(1'b1, 12'h000, {25'h0, c});
        apb(1'b1, 12'h00c, {16'h0, a});
        @(posedge i_clk) i_ccp_unlock <= 1'b1;
        @(posedge i_clk) i_ccp_unlock <= 1'b0;
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        st = rd;
        idle();
        apb(1'b0, 12'h004, 32'h0);
        chk("strobe_after", rd[0], 1'b0);
    endtask
    // Read one EEPROM byte through the data register
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
        exec(7'h06, a);
        apb(1'b0, 12'h010, 32'h0);
        chk("data_low", rd, {24'h0, e});
    endtask
    task automatic load(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, 12'h00c, {16'h0, a});
        apb(1'b1, 12'h010, {24'h0, d});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog, about 30000 cycles
    initial begin
        #3000000;
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk("status_reset", rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", err, 1'b1);
        apb(1'b1, 12'h000, 32'h36);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk("locked_strobe", rd, 32'h0);
        apb(1'b1, 12'h000, 32'h33);
        load(16'h0025, 8'ha5);
        load(16'h0026, 8'h5a);
        exec(7'h34, 16'h0020);
        chk("busy_write", st[7], 1'b1);
        rdchk(16'h0025, 8'ha5);
        rdchk(16'h0027, 8'hff);
        exec(7'h36, 16'h0000);
        exec(7'h32, 16'h0020);
        rdchk(16'h0025, 8'ha5);
        apb(1'b1, 12'h000, 32'h33);
        load(16'h0025, 8'h11);
        exec(7'h32, 16'h0020);
        rdchk(16'h0025, 8'hff);
        rdchk(16'h0026, 8'h5a);
        exec(7'h35, 16'h0060);
        rdchk(16'h0065, 8'h11);
        exec(7'h30, 16'h0000);
        rdchk(16'h0065, 8'hff);
        rdchk(16'h0026, 8'h5a);
        prog.enable_link(ok);
        chk("enabled", ok, 1'b1);
        apb(1'b1, 12'h000, 32'h33);
        prog.xfer(1'b1, 25'h08c0047, 8'h3c);
        apb(1'b1, 12'h000, 32'h34);
        prog.xfer(1'b1, 25'h08c0040, 8'h00);
        @(posedge i_clk);
        chk("busy_pin", o_busy, 1'b1);
        idle();
        chk("idle_pin", o_busy, 1'b0);
        apb(1'b1, 12'h000, 32'h06);
        prog.xfer(1'b0, 25'h08c0047, 8'h00);
        @(posedge i_clk);
        chk("dbg_rdata", o_dbg_rdata, 8'h3c);
        for (int i = 0; i < 6; i++) begin
            prog.xfer(1'b0, base[i], 8'h00);
            @(posedge i_clk);
            chk("region", o_dbg_region, i + 1);
        end
        conclude();
    end
endmodule
